// ---- srs_params.svh ----
// constants of the status reporting block: offsets, bit positions, codes
// assumes an 8-bit byte address on the register bus
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
// ==========================================
// register byte offsets
`define SRS_OFF_STB 8'h00
`define SRS_OFF_SRE 8'h04
`define SRS_OFF_ESR 8'h08
`define SRS_OFF_ESE 8'h0c
`define SRS_OFF_PPE 8'h10
`define SRS_OFF_OPER_EVT 8'h14
`define SRS_OFF_OPER_EN 8'h18
`define SRS_OFF_QUES_EVT 8'h1c
`define SRS_OFF_QUES_EN 8'h20
`define SRS_OFF_ERRQ 8'h24
`define SRS_OFF_CMD 8'h28
`define SRS_OFF_SYNC 8'h2c
`define SRS_OFF_ID 8'h30
`define SRS_OFF_BOOL 8'h34
`define SRS_OFF_OPER_COND 8'h38
`define SRS_OFF_QUES_COND 8'h3c
`define SRS_OFF_SERIAL 8'h40
// ==========================================
// status byte and event bit positions
`define SRS_STB_EAV 2
`define SRS_STB_QUES 3
`define SRS_STB_MAV 4
`define SRS_STB_ESB 5
`define SRS_STB_RQS 6
`define SRS_STB_OPER 7
`define SRS_ESR_OPC 0
`define SRS_ERRQ_VALID 16
// ==========================================
// command codes, reset values, replies
`define SRS_CMD_OPC 8'h01
`define SRS_CMD_OPCQ 8'h02
`define SRS_CMD_WAI 8'h03
`define SRS_CMD_CLS 8'h04
`define SRS_RST_BYTE 8'h00
`define SRS_RQS_OFF 8'hbf
`define SRS_OPC_REPLY 8'h01
`define SRS_RESP_OKAY 2'b00
`define SRS_RESP_SLVERR 2'b10
`endif

// ---- srs_pkg.sv ----
// types of the status reporting block
// assumes nothing of its surroundings
package srs_pkg;
  // ==========================================
  // command synchronisation states
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_OPCQ, ST_RPLY, ST_WAI} srs_state_t;
endpackage

// ---- srs_subreg.sv ----
// one status sub-register: condition, rising-edge event latch, enable, summary
// assumes condition inputs synchronous to aclk
`timescale 1ns/1ps
module srs_subreg #(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] cond,
  input wire logic en_we,
  input wire logic [WIDTH-1:0] en_wdata,
  input wire logic [WIDTH-1:0] en_wmask,
  input wire logic evt_rd,
  input wire logic cls,
  output logic [WIDTH-1:0] evt,
  output logic [WIDTH-1:0] en,
  output logic summary
);
  logic [WIDTH-1:0] cond_ff, evt_ff, en_ff, nxt_cond, nxt_evt, nxt_en;
  // ==========================================
  // next values; a new edge wins over a read or clear
  always_comb
  begin
    nxt_cond = cond;
    nxt_evt = evt_ff;
    if (evt_rd || cls)
    begin
      nxt_evt = '0;
    end
    nxt_evt = nxt_evt | (cond & ~cond_ff);
    nxt_en = en_we ? ((en_ff & ~en_wmask) | (en_wdata & en_wmask)) : en_ff;
  end
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cond_ff <= '0;
      evt_ff <= '0;
      en_ff <= '0;
    end
    else if (ce)
    begin
      cond_ff <= nxt_cond;
      evt_ff <= nxt_evt;
      en_ff <= nxt_en;
    end
  end
  // outputs
  assign evt = evt_ff;
  assign en = en_ff;
  assign summary = |(evt_ff & en_ff);
endmodule // srs_subreg

// ---- srs_errq.sv ----
// error queue: first in first out, drops new codes when full
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module srs_errq #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_code,
  input wire logic pop,
  input wire logic cls,
  output logic [WIDTH-1:0] head,
  output logic not_empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] rd_ff, wr_ff, nxt_rd, nxt_wr;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic wr_en;
  // ==========================================
  // pointer update; a push in the clearing cycle is kept
  always_comb
  begin
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_cnt = cnt_ff;
    if (cls)
    begin
      nxt_rd = wr_ff;
      nxt_cnt = '0;
    end
    else if (pop && cnt_ff != '0)
    begin
      nxt_rd = rd_ff + 1'b1;
      nxt_cnt = cnt_ff - 1'b1;
    end
    wr_en = push && (nxt_cnt != (AW+1)'(DEPTH));
    if (wr_en)
    begin
      nxt_wr = wr_ff + 1'b1;
      nxt_cnt = nxt_cnt + 1'b1;
    end
  end
  // pointer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end
  // storage
  always_ff @(posedge aclk)
  begin
    if (ce && wr_en)
    begin
      mem_ff[wr_ff] <= push_code;
    end
  end
  assign head = mem_ff[rd_ff];
  assign not_empty = (cnt_ff != '0);
endmodule // srs_errq

// ---- srs_status_top.sv ----
// status reporting and command synchronisation behind an axi4-lite slave
// assumes the command decoder of the usb test-class transport writes the
// sync commands, and the execution engine reports busy and settled levels
//
// Functional notes
// - opc sets esr bit0 once all done
// - opc query waits for bit0, replies 1
// - wai blocks commands other than cls until everything completes
// - ese bit0 plus sre bit5 give srq
// - status byte gathers summaries, sre masks srq
// - ese masks esr into its summary
// - operation and questionable share one structure
// - ist is ppe-selected status byte bits
// - mav follows the output buffer
// - status registers and error queue readable
// - only the device raises service requests
// - sync commands wait for applied hardware
// - commands arrive over usb test class
// - fixed vendor, product and serial identifiers
// - boolean reads answer 1 for true
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "srs_params.svh"
module srs_status_top #(
  parameter int ERRQ_DEPTH = 8,
  parameter int ERR_W = 16,
  parameter int COND_W = 16,
  parameter logic [15:0] DEV_VID = 16'h1a2b, // arbitrary value
  parameter logic [15:0] DEV_PID = 16'h3c4d, // arbitrary value
  parameter logic [31:0] DEV_SERIAL = 32'h0000_0001 // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic ops_busy,
  input wire logic hw_settled,
  input wire logic [7:1] esr_evt,
  input wire logic [COND_W-1:0] oper_cond,
  input wire logic [COND_W-1:0] ques_cond,
  input wire logic err_push,
  input wire logic [ERR_W-1:0] err_code,
  input wire logic out_buf_pending,
  output logic cmd_hold,
  output logic reply_valid,
  output logic [7:0] reply_data,
  output logic srq,
  output logic ist
);
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff, nxt_aw, nxt_w, nxt_bvalid, nxt_rvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, rdata_ff, nxt_wdata, nxt_rdata, wmask, rd_val;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  logic [7:0] sre_ff, ese_ff, ppe_ff, esr_ff, nxt_sre, nxt_ese, nxt_ppe, nxt_esr;
  logic bool_ff, nxt_bool, reply_ff, nxt_reply, srq_ff, ist_ff, nxt_srq, nxt_ist;
  logic [7:0] stb;
  logic [COND_W-1:0] oper_evt, oper_en, ques_evt, ques_en;
  logic [ERR_W-1:0] errq_head;
  logic oper_sum, ques_sum, errq_ne, wr_go, rd_go, rd_hit, done, cmd_go, cls_go, opc_set;
  srs_pkg::srs_state_t st_ff, nxt_st;
  // ==========================================
  // axi4-lite handshakes and byte lane mask
  assign awready = ce && !aw_ff;
  assign wready = ce && !w_ff;
  assign arready = ce && !rvalid_ff;
  assign wr_go = ce && aw_ff && w_ff && !bvalid_ff;
  assign rd_go = arvalid && arready;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
    end
  endgenerate
  // write strobes into the register bank
  assign cmd_go = wr_go && awaddr_ff == `SRS_OFF_CMD && wmask[0] && st_ff == srs_pkg::ST_IDLE;
  assign cls_go = wr_go && awaddr_ff == `SRS_OFF_CMD && wmask[0] && wdata_ff[7:0] == `SRS_CMD_CLS;
  assign done = hw_settled && !ops_busy;
  // ==========================================
  // status byte; summaries gathered here
  always_comb
  begin
    stb = `SRS_RST_BYTE;
    stb[`SRS_STB_EAV] = errq_ne;
    stb[`SRS_STB_QUES] = ques_sum;
    stb[`SRS_STB_OPER] = oper_sum;
    stb[`SRS_STB_MAV] = out_buf_pending;
    stb[`SRS_STB_ESB] = |(esr_ff & ese_ff);
    // esb through sre bit5 raises rqs
    stb[`SRS_STB_RQS] = |(stb & sre_ff & `SRS_RQS_OFF);
  end
  // ==========================================
  // axi channel next state and read mux
  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w = w_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff && !bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    rd_hit = 1'b1;
    if (awvalid && awready)
    begin
      nxt_aw = 1'b1;
      nxt_awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      nxt_w = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      case (awaddr_ff)
        `SRS_OFF_SRE, `SRS_OFF_ESE, `SRS_OFF_PPE, `SRS_OFF_OPER_EN, `SRS_OFF_QUES_EN, `SRS_OFF_BOOL:
          nxt_bresp = `SRS_RESP_OKAY;
        // refused while a sync command is still pending, except cls, which is always taken
        `SRS_OFF_CMD: nxt_bresp = (cmd_go || cls_go) ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
        default: nxt_bresp = `SRS_RESP_SLVERR;
      endcase
    end
    case (araddr)
      `SRS_OFF_STB: rd_val = {24'h0, stb};
      `SRS_OFF_SRE: rd_val = {24'h0, sre_ff};
      `SRS_OFF_ESR: rd_val = {24'h0, esr_ff};
      `SRS_OFF_ESE: rd_val = {24'h0, ese_ff};
      `SRS_OFF_PPE: rd_val = {24'h0, ppe_ff};
      `SRS_OFF_OPER_EVT: rd_val = 32'(oper_evt);
      `SRS_OFF_OPER_EN: rd_val = 32'(oper_en);
      `SRS_OFF_QUES_EVT: rd_val = 32'(ques_evt);
      `SRS_OFF_QUES_EN: rd_val = 32'(ques_en);
      `SRS_OFF_OPER_COND: rd_val = 32'(oper_cond);
      `SRS_OFF_QUES_COND: rd_val = 32'(ques_cond);
      `SRS_OFF_ERRQ: rd_val = errq_ne ? 32'({1'b1, errq_head}) : 32'h0; // empty queue reads 0, not a stale slot
      `SRS_OFF_SYNC: rd_val = {29'h0, ops_busy, hw_settled, cmd_hold};
      `SRS_OFF_ID: rd_val = {DEV_PID, DEV_VID};
      `SRS_OFF_SERIAL: rd_val = DEV_SERIAL;
      `SRS_OFF_BOOL: rd_val = {31'h0, bool_ff};
      default:
      begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    if (rd_go)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_val;
      nxt_rresp = rd_hit ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
    end
  end
  // axi channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SRS_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `SRS_RESP_OKAY;
    end
    else if (ce)
    begin
      aw_ff <= nxt_aw;
      awaddr_ff <= nxt_awaddr;
      w_ff <= nxt_w;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  // ==========================================
  // sync command sequencer and mask registers
  always_comb
  begin
    nxt_st = st_ff;
    opc_set = 1'b0;
    case (st_ff)
      srs_pkg::ST_IDLE:
        // commands from the usb test-class decoder
        if (cmd_go)
        begin
          case (wdata_ff[7:0])
            `SRS_CMD_OPC: nxt_st = srs_pkg::ST_OPC;
            `SRS_CMD_OPCQ: nxt_st = srs_pkg::ST_OPCQ;
            `SRS_CMD_WAI: nxt_st = srs_pkg::ST_WAI;
            default: nxt_st = srs_pkg::ST_IDLE;
          endcase
        end
      srs_pkg::ST_OPC:
        if (done)
        begin
          opc_set = 1'b1;
          nxt_st = srs_pkg::ST_IDLE;
        end
      srs_pkg::ST_OPCQ:
        if (done)
        begin
          opc_set = 1'b1;
          nxt_st = srs_pkg::ST_RPLY;
        end
      srs_pkg::ST_RPLY: nxt_st = srs_pkg::ST_IDLE;
      srs_pkg::ST_WAI:
        if (done)
        begin
          nxt_st = srs_pkg::ST_IDLE;
        end
      default: nxt_st = srs_pkg::ST_IDLE;
    endcase
    nxt_reply = (st_ff == srs_pkg::ST_RPLY);
    nxt_sre = (wr_go && awaddr_ff == `SRS_OFF_SRE) ? (sre_ff & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]) : sre_ff;
    nxt_ese = (wr_go && awaddr_ff == `SRS_OFF_ESE) ? (ese_ff & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]) : ese_ff;
    nxt_ppe = (wr_go && awaddr_ff == `SRS_OFF_PPE) ? (ppe_ff & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]) : ppe_ff;
    nxt_bool = (wr_go && awaddr_ff == `SRS_OFF_BOOL && wmask[0]) ? (wdata_ff != 32'h0) : bool_ff;
    // read or clear empties esr; new events win
    nxt_esr = (cls_go || (rd_go && araddr == `SRS_OFF_ESR)) ? 8'h00 : esr_ff;
    nxt_esr = nxt_esr | {esr_evt, opc_set};
    // service request from own state only
    nxt_srq = stb[`SRS_STB_RQS];
    nxt_ist = |(stb & ppe_ff);
  end
  // sequencer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= srs_pkg::ST_IDLE;
      reply_ff <= 1'b0;
      sre_ff <= `SRS_RST_BYTE;
      ese_ff <= `SRS_RST_BYTE;
      ppe_ff <= `SRS_RST_BYTE;
      esr_ff <= `SRS_RST_BYTE;
      bool_ff <= 1'b0;
      srq_ff <= 1'b0;
      ist_ff <= 1'b0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      reply_ff <= nxt_reply;
      sre_ff <= nxt_sre;
      ese_ff <= nxt_ese;
      ppe_ff <= nxt_ppe;
      esr_ff <= nxt_esr;
      bool_ff <= nxt_bool;
      srq_ff <= nxt_srq;
      ist_ff <= nxt_ist;
    end
  end
  assign cmd_hold = (st_ff != srs_pkg::ST_IDLE);
  assign reply_valid = reply_ff;
  assign reply_data = `SRS_OPC_REPLY;
  assign srq = srq_ff;
  assign ist = ist_ff;
  // ==========================================
  // operation and questionable sub-registers, error queue
  srs_subreg #(.WIDTH(COND_W)) u_oper (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cond(oper_cond),
    .en_we(wr_go && awaddr_ff == `SRS_OFF_OPER_EN), .en_wdata(wdata_ff[COND_W-1:0]),
    .en_wmask(wmask[COND_W-1:0]), .evt_rd(rd_go && araddr == `SRS_OFF_OPER_EVT), .cls(cls_go),
    .evt(oper_evt), .en(oper_en), .summary(oper_sum));
  srs_subreg #(.WIDTH(COND_W)) u_ques (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cond(ques_cond),
    .en_we(wr_go && awaddr_ff == `SRS_OFF_QUES_EN), .en_wdata(wdata_ff[COND_W-1:0]),
    .en_wmask(wmask[COND_W-1:0]), .evt_rd(rd_go && araddr == `SRS_OFF_QUES_EVT), .cls(cls_go),
    .evt(ques_evt), .en(ques_en), .summary(ques_sum));
  srs_errq #(.DEPTH(ERRQ_DEPTH), .WIDTH(ERR_W)) u_errq (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .push(err_push), .push_code(err_code), .pop(rd_go && araddr == `SRS_OFF_ERRQ), .cls(cls_go),
    .head(errq_head), .not_empty(errq_ne));
  // ==========================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  opc_done_set_a: assert property (ce && st_ff == srs_pkg::ST_OPC && done |=> esr_ff[0] && !cmd_hold)
    else $error("opc bit not set on completion");
  opcq_reply_a: assert property (ce && st_ff == srs_pkg::ST_RPLY |-> esr_ff[0] ##1 reply_valid && reply_data == 8'h01)
    else $error("opc query reply wrong");
  wai_block_a: assert property (ce && st_ff == srs_pkg::ST_WAI && !done |=> cmd_hold)
    else $error("wai released early");
  opc_srq_a: assert property (ce && esr_ff[0] && ese_ff[0] && sre_ff[5] |=> srq)
    else $error("no srq after opc");
  rqs_sum_a: assert property (stb[6] == |({oper_sum, 1'b0, |(esr_ff & ese_ff), out_buf_pending, ques_sum, errq_ne, 2'b00} & sre_ff))
    else $error("request summary wrong");
  esb_mask_a: assert property (stb[5] == |(esr_ff & ese_ff))
    else $error("event summary wrong");
  oper_rise_a: assert property (ce && $past(ce) && $rose(oper_cond[0]) && oper_en[0] && !wr_go |=> stb[7])
    else $error("operation summary missed");
  ist_sel_a: assert property (ce |=> ist == $past(|(stb & ppe_ff)))
    else $error("ist wrong");
  mav_buf_a: assert property (stb[4] == out_buf_pending)
    else $error("mav wrong");
  errq_seen_a: assert property (ce && err_push && !cls_go |=> stb[2])
    else $error("queued error not visible");
  srq_mask_a: assert property (ce && sre_ff == 8'h00 && !wr_go |=> !srq)
    else $error("srq without enable");
  settle_hold_a: assert property (ce && st_ff != srs_pkg::ST_IDLE && st_ff != srs_pkg::ST_RPLY && !hw_settled |=> $stable(st_ff))
    else $error("sync acted before settling");
  id_fixed_a: assert property (rd_go && araddr == `SRS_OFF_ID |=> rdata == {DEV_PID, DEV_VID})
    else $error("identifier changed");
  bool_one_a: assert property (ce && wr_go && awaddr_ff == `SRS_OFF_BOOL && wmask[0] && wdata_ff != 32'h0 |=> bool_ff)
    else $error("true not stored as 1");
  cls_keep_a: assert property (cls_go && esr_evt == 7'h0 && !opc_set |=> esr_ff == 8'h00 && $stable(ese_ff) && $stable(sre_ff))
    else $error("clear touched masks or kept events");
  opc_srq_c: cover property (cmd_go && wdata_ff[7:0] == `SRS_CMD_OPC ##[1:50] srq);
  opcq_c: cover property (reply_valid);
  errq_pop_c: cover property (rd_go && araddr == `SRS_OFF_ERRQ && errq_ne);
endmodule // srs_status_top

// ---- srs_engine_model.sv ----
// execution engine model: one overlapped operation with a late settle phase
// assumes go is a one-cycle pulse synchronous to aclk
`timescale 1ns/1ps
module srs_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [7:0] run_len,
  output logic ops_busy,
  output logic hw_settled
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  // ==========================================
  // operation counter
  // loads on go, counts down to idle
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (go)
      nxt_cnt = run_len;
    else if (cnt_ff != 8'h00)
      nxt_cnt = cnt_ff - 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= nxt_cnt;
  end
  assign hw_settled = cnt_ff < 8'h04; // settled in the last three cycles of a run and while idle
  assign ops_busy = cnt_ff != 8'h00;
endmodule // srs_engine_model

// ---- ieee4882_status_reporting_test.sv ----
// testbench of the status block: axi4-lite tasks and directed tests
// assumes the engine model drives busy and settled levels
`timescale 1ns/1ps
`include "srs_params.svh"
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ieee4882_status_reporting_test;
  localparam logic [15:0] VID = 16'h1a2b; // arbitrary value
  localparam logic [15:0] PID = 16'h3c4d; // arbitrary value
  localparam logic [31:0] SER = 32'h0000_0001; // arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, run_len = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [7:1] esr_evt = 7'h00;
  logic [15:0] oper_cond = 16'h0, ques_cond = 16'h0, err_code = 16'h0;
  logic err_push = 1'b0, out_buf_pending = 1'b0, go = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ops_busy, hw_settled;
  logic cmd_hold, reply_valid, srq, ist;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] reply_data;
  int n_mismatch = 0;
  int n_tests = 0;
  int i;
  // ==========================================
  // clock, design and engine model
  always #20 aclk = ~aclk;
  srs_status_top #(.DEV_VID(VID), .DEV_PID(PID), .DEV_SERIAL(SER)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ops_busy(ops_busy), .hw_settled(hw_settled), .esr_evt(esr_evt), .oper_cond(oper_cond),
    .ques_cond(ques_cond), .err_push(err_push), .err_code(err_code), .out_buf_pending(out_buf_pending),
    .cmd_hold(cmd_hold), .reply_valid(reply_valid), .reply_data(reply_data), .srq(srq), .ist(ist));
  srs_engine_model u_eng (.aclk(aclk), .aresetn(aresetn), .go(go), .run_len(run_len),
    .ops_busy(ops_busy), .hw_settled(hw_settled));
  // ==========================================
  // bus tasks: ready sampled at negedge, taken at the next posedge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, dn;
    logic [1:0] r;
    int t;
    dn = 1'b0;
    r = 2'b11;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 40 && !dn; t++)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      dn = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (dn)
        bready <= 1'b0;
    end
    `CHK(r, er)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, dn;
    logic [1:0] r;
    logic [31:0] d;
    int t;
    dn = 1'b0;
    r = 2'b11;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 40 && !dn; t++)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      dn = rvalid;
      r = rresp;
      d = rdata;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (dn)
        rready <= 1'b0;
    end
    `CHK(d, ed)
    `CHK(r, er)
    @(posedge aclk);
  endtask
  // start an engine run of n cycles
  task automatic start(input logic [7:0] n);
    go <= 1'b1;
    run_len <= n;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  // wait for a level on a design output, bounded
  task automatic wait_for(input bit want_reply);
    int t;
    for (t = 0; t < 100 && (want_reply ? reply_valid !== 1'b1 : cmd_hold !== 1'b0); t++)
      @(negedge aclk);
    `CHK(want_reply ? reply_valid : ~cmd_hold, 1'b1)
    // next request starts just after a rising edge
    @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop();
  end
  // ==========================================
  // test sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SRS_OFF_STB, 32'h0, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ID, {PID, VID}, `SRS_RESP_OKAY);
    rd(`SRS_OFF_SERIAL, SER, `SRS_RESP_OKAY);
    wr(`SRS_OFF_ID, 32'h0, `SRS_RESP_SLVERR);
    rd(8'h44, 32'h0, `SRS_RESP_SLVERR);
    wr(`SRS_OFF_STB, 32'hff, `SRS_RESP_SLVERR);
    `CHK(srq, 1'b0)
    $display("test reset done");
    wr(`SRS_OFF_ESE, 32'h1, `SRS_RESP_OKAY);
    wr(`SRS_OFF_SRE, 32'h20, `SRS_RESP_OKAY);
    start(8'd30);
    // one command per write keeps the order fixed
    wr(`SRS_OFF_CMD, 32'h1, `SRS_RESP_OKAY);
    `CHK(cmd_hold, 1'b1)
    `CHK(srq, 1'b0)
    wait_for(1'b0);
    rd(`SRS_OFF_STB, 32'h60, `SRS_RESP_OKAY);
    `CHK(srq, 1'b1)
    rd(`SRS_OFF_ESR, 32'h1, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ESR, 32'h0, `SRS_RESP_OKAY);
    rd(`SRS_OFF_STB, 32'h0, `SRS_RESP_OKAY);
    `CHK(srq, 1'b0)
    $display("test opc done");
    start(8'd30);
    // query sent apart from any setting
    wr(`SRS_OFF_CMD, 32'h2, `SRS_RESP_OKAY);
    wr(`SRS_OFF_CMD, 32'h1, `SRS_RESP_SLVERR);
    wait_for(1'b1);
    `CHK(reply_data, `SRS_OPC_REPLY)
    @(posedge aclk);
    rd(`SRS_OFF_ESR, 32'h1, `SRS_RESP_OKAY);
    $display("test opc query done");
    start(8'd30);
    wr(`SRS_OFF_CMD, 32'h3, `SRS_RESP_OKAY);
    `CHK(cmd_hold, 1'b1)
    wait_for(1'b0);
    `CHK(ops_busy, 1'b0)
    @(posedge aclk);
    rd(`SRS_OFF_ESR, 32'h0, `SRS_RESP_OKAY);
    $display("test wai done");
    out_buf_pending <= 1'b1;
    @(posedge aclk);
    rd(`SRS_OFF_STB, 32'h10, `SRS_RESP_OKAY);
    wr(`SRS_OFF_PPE, 32'h10, `SRS_RESP_OKAY);
    `CHK(ist, 1'b1)
    wr(`SRS_OFF_PPE, 32'h08, `SRS_RESP_OKAY);
    `CHK(ist, 1'b0)
    out_buf_pending <= 1'b0;
    @(posedge aclk);
    rd(`SRS_OFF_STB, 32'h0, `SRS_RESP_OKAY);
    $display("test mav ist done");
    for (i = 0; i < 2; i++)
    begin
      wr(i ? `SRS_OFF_QUES_EN : `SRS_OFF_OPER_EN, 32'h1, `SRS_RESP_OKAY);
      oper_cond <= i ? 16'h0 : 16'h1;
      ques_cond <= i ? 16'h1 : 16'h0;
      @(posedge aclk);
      rd(`SRS_OFF_STB, i ? 32'h08 : 32'h80, `SRS_RESP_OKAY);
      rd(i ? `SRS_OFF_QUES_EVT : `SRS_OFF_OPER_EVT, 32'h1, `SRS_RESP_OKAY);
      rd(i ? `SRS_OFF_QUES_EVT : `SRS_OFF_OPER_EVT, 32'h0, `SRS_RESP_OKAY);
    end
    rd(`SRS_OFF_QUES_COND, 32'h1, `SRS_RESP_OKAY);
    rd(`SRS_OFF_SYNC, 32'h2, `SRS_RESP_OKAY);
    $display("test summaries done");
    err_code <= 16'h0123;
    err_push <= 1'b1;
    esr_evt <= 7'h02;
    @(posedge aclk);
    err_push <= 1'b0;
    esr_evt <= 7'h00;
    @(posedge aclk);
    rd(`SRS_OFF_STB, 32'h04, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ERRQ, 32'h0001_0123, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ERRQ, 32'h0, `SRS_RESP_OKAY);
    err_push <= 1'b1;
    @(posedge aclk);
    err_push <= 1'b0;
    wr(`SRS_OFF_CMD, 32'h4, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ESR, 32'h0, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ERRQ, 32'h0, `SRS_RESP_OKAY);
    rd(`SRS_OFF_ESE, 32'h1, `SRS_RESP_OKAY);
    $display("test errq clear done");
    for (i = 0; i < 3; i++)
    begin
      wr(`SRS_OFF_BOOL, i == 0 ? 32'hff : (i == 1 ? 32'h0 : 32'h1), `SRS_RESP_OKAY);
      rd(`SRS_OFF_BOOL, i == 1 ? 32'h0 : 32'h1, `SRS_RESP_OKAY);
    end
    $display("test bool done");
    report_and_stop();
  end
endmodule // ieee4882_status_reporting_test
